// *** tom_decoder.v ***
// top-of-memory region decoder with its limit and configuration registers
// assumes a one-cycle access request and a model-specific register port
// limits and configuration reset to zero, so every access starts as io
`timescale 1ns/100ps
`default_nettype none
`include "tom_regs.vh"
module tom_decoder #(
	parameter PA_W = `TOM_ADDR_W
) (
	input  wire            ref_clk_i,
	input  wire            reset_i,
	input  wire            reg_wr_i,
	input  wire            reg_rd_i,
	input  wire [1:0]      reg_sel_i,
	input  wire [63:0]     reg_wdata_i,
	output reg  [63:0]     reg_rdata_o,
	output reg             reg_ack_o,
	input  wire            acc_valid_i,
	input  wire [PA_W-1:0] acc_addr_i,
	input  wire            acc_write_i,
	input  wire [4:0]      acc_type_i,
	output reg             acc_valid_o,
	output reg             acc_to_mem_o,
	output reg             acc_in_limit_o,
	output reg  [2:0]      acc_mem_type_o
);
	// storage for the two limits and the configuration word
	reg  [63:0]  low_memory_limit;
	reg  [63:0]  high_memory_limit;
	reg  [63:0]  system_configuration_register;

	// register port decode
	wire         sel_low;
	wire         sel_high;
	wire         sel_cfg;
	wire         wr_low;
	wire         wr_high;
	wire         wr_cfg;
	wire         reg_strobe;
	reg  [63:0]  next_rdata;

	// both limits side by side, low in the bottom word
	wire [127:0] limit_flat;
	wire [1:0]   limit_below;
	wire         low_limit_enable;
	wire         high_limit_enable;
	wire         below_low;
	wire         below_high;

	// address space split at the 4 GiB edge
	wire         above_4g;
	wire         low_space;

	// decision terms
	reg          in_low_region;
	reg          in_high_region;
	reg          region_hit;
	reg          rd_route;
	reg          wr_route;
	reg          route_bit;
	reg          next_valid;
	reg          next_in_limit;
	reg          next_to_mem;
	reg  [2:0]   next_mem_type;

	genvar       gi;

	// enables live in the configuration word
	assign low_limit_enable  = system_configuration_register[`TOM_CFG_LOW_EN];
	assign high_limit_enable = system_configuration_register[`TOM_CFG_HIGH_EN];

	assign sel_low    = (reg_sel_i == `TOM_SEL_LOW);
	assign sel_high   = (reg_sel_i == `TOM_SEL_HIGH);
	assign sel_cfg    = (reg_sel_i == `TOM_SEL_CFG);
	assign wr_low     = reg_wr_i & sel_low;
	assign wr_high    = reg_wr_i & sel_high;
	assign wr_cfg     = reg_wr_i & sel_cfg;
	assign reg_strobe = reg_wr_i | reg_rd_i;

	assign limit_flat = {high_memory_limit, low_memory_limit};

	// one comparator per limit, limit field only
	generate
		for (gi = 0; gi < `TOM_LIM_CNT; gi = gi + 1) begin : g_limit
			tom_cmp #(
				.PA_W(PA_W)
			) u_cmp (
				.addr_i  (acc_addr_i),
				.limit_i (limit_flat[gi*`TOM_LIM_W +: `TOM_LIM_W]),
				.below_o (limit_below[gi])
			);
		end
	endgenerate

	assign below_low  = limit_below[`TOM_SLOT_LOW];
	assign below_high = limit_below[`TOM_SLOT_HIGH];

	assign above_4g  = |acc_addr_i[PA_W-1:`TOM_FOUR_GIB_BIT];
	assign low_space = ~above_4g;

	// each region only counts while its limit is enabled
	always @* begin
		in_low_region  = low_space & low_limit_enable & below_low;
		in_high_region = above_4g & high_limit_enable & below_high;
		region_hit     = in_low_region | in_high_region;
	end

	// per-direction routing bits of the effective type
	always @* begin
		rd_route = acc_type_i[`TOM_TYPE_RD_BIT];
		wr_route = acc_type_i[`TOM_TYPE_WR_BIT];
		if (acc_write_i) begin
			route_bit = wr_route;
		end else begin
			route_bit = rd_route;
		end
	end

	// memory only where both the limit and the type say so
	always @* begin
		next_valid    = acc_valid_i;
		next_in_limit = acc_valid_i & region_hit;
		next_to_mem   = acc_valid_i & region_hit & route_bit;
		next_mem_type = acc_type_i[`TOM_MT_HI:`TOM_MT_LO];
	end

	// read data holds until the next read; unmapped select reads zero
	always @* begin
		next_rdata = reg_rdata_o;
		if (reg_rd_i) begin
			case (reg_sel_i)
			`TOM_SEL_LOW: begin
				next_rdata = low_memory_limit;
			end
			`TOM_SEL_HIGH: begin
				next_rdata = high_memory_limit;
			end
			`TOM_SEL_CFG: begin
				next_rdata = system_configuration_register;
			end
			default: begin
				next_rdata = `TOM_UNMAPPED_RD;
			end
			endcase
		end
	end

	// reserved bits are kept for read-back, never decoded
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			low_memory_limit <= `TOM_LIM_RESET;
		end else if (wr_low) begin
			low_memory_limit <= reg_wdata_i;
		end
	end

	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			high_memory_limit <= `TOM_LIM_RESET;
		end else if (wr_high) begin
			high_memory_limit <= reg_wdata_i;
		end
	end

	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			system_configuration_register <= `TOM_CFG_RESET;
		end else if (wr_cfg) begin
			system_configuration_register <= reg_wdata_i;
		end
	end

	// register port answers one cycle after the strobe
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			reg_ack_o   <= 1'b0;
			reg_rdata_o <= `TOM_RDATA_RESET;
		end else begin
			reg_ack_o   <= reg_strobe;
			reg_rdata_o <= next_rdata;
		end
	end

	// access answer one cycle after the request
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc_valid_o <= 1'b0;
		end else begin
			acc_valid_o <= next_valid;
		end
	end

	// region flag, low when no access
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc_in_limit_o <= 1'b0;
		end else begin
			acc_in_limit_o <= next_in_limit;
		end
	end

	// routing verdict, io when no access
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc_to_mem_o <= 1'b0;
		end else begin
			acc_to_mem_o <= next_to_mem;
		end
	end

	// type passes through beside the verdict
	always @(posedge ref_clk_i or posedge reset_i) begin
		if (reset_i) begin
			acc_mem_type_o <= `TOM_MT_RESET;
		end else begin
			acc_mem_type_o <= next_mem_type;
		end
	end
endmodule // tom_decoder
`default_nettype wire

// *** tom_regs.vh ***
// constants for the top-of-memory region decoder
// assumes a model-specific register port with indexed selects
`ifndef TOM_REGS_VH
`define TOM_REGS_VH
`define TOM_ADDR_W       52
`define TOM_LIM_HI       51
`define TOM_LIM_LO       23
`define TOM_FOUR_GIB_BIT 32
`define TOM_SEL_LOW      2'h0
`define TOM_SEL_HIGH     2'h1
`define TOM_SEL_CFG      2'h2
`define TOM_CFG_LOW_EN   20
`define TOM_CFG_HIGH_EN  21
`define TOM_TYPE_RD_BIT  4
`define TOM_TYPE_WR_BIT  3
`define TOM_LIM_RESET    64'h0000_0000_0000_0000
`define TOM_CFG_RESET    64'h0000_0000_0000_0000
`define TOM_LIM_W        64
`define TOM_LIM_CNT      2
`define TOM_SLOT_LOW     0
`define TOM_SLOT_HIGH    1
`define TOM_MT_HI        2
`define TOM_MT_LO        0
`define TOM_UNMAPPED_RD  64'h0000_0000_0000_0000
`define TOM_RDATA_RESET  64'h0000_0000_0000_0000
`define TOM_MT_RESET     3'h0
`endif

// *** tom_cmp.v ***
// limit comparator: address below an 8 MiB aligned limit field
// assumes address and limit share the implemented width
`timescale 1ns/100ps
`default_nettype none
`include "tom_regs.vh"
module tom_cmp #(
	parameter PA_W = `TOM_ADDR_W
) (
	input  wire [PA_W-1:0] addr_i,
	input  wire [63:0]     limit_i,
	output wire            below_o
);
	// only the limit field and implemented bits take part
	wire [PA_W-1:`TOM_LIM_LO] lim_field = limit_i[PA_W-1:`TOM_LIM_LO];
	assign below_o = addr_i[PA_W-1:`TOM_LIM_LO] < lim_field;
endmodule // tom_cmp
`default_nettype wire

// *** tom_decoder_properties.sv ***
// routing assertions for the region decoder
// bound into every tom_decoder, one clock domain
`timescale 1ns/100ps
`default_nettype none
module tom_decoder_chk (input wire logic ref_clk_i, reset_i, acc_valid_i, acc_write_i,
	input wire logic [4:0] acc_type_i, input wire logic acc_to_mem_o, acc_in_limit_o, acc_valid_o);
	wire logic m = acc_to_mem_o;
	wire logic rd = acc_valid_i & ~acc_write_i;
	wire logic wt = acc_valid_i & acc_write_i;
	wire logic eq = acc_to_mem_o == acc_in_limit_o;
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);
	chk_rd_io: assert property (rd && !acc_type_i[4] |=> !m) else $error("misrouted read");
	chk_wr_io: assert property (wt && !acc_type_i[3] |=> !m) else $error("misrouted write");
	chk_rd_mem: assert property (rd && acc_type_i[4] |=> eq) else $error("read route");
	chk_wr_mem: assert property (wt && acc_type_i[3] |=> eq) else $error("write route");
	chk_mem_limit: assert property (m |-> acc_in_limit_o) else $error("outside limit");
	chk_idle_io: assert property (!acc_valid_i |=> !m) else $error("idle to memory");
	chk_mem_cause: assert property ($rose(m) |-> $past(acc_valid_i)) else $error("no cause");
	chk_shadow_rd: assert property (rd && acc_type_i[4:3] == 2'h1 |=> !m) else $error("shadow");
	chk_valid_echo: assert property (acc_valid_i |=> acc_valid_o) else $error("no answer");
endmodule // tom_decoder_chk
bind tom_decoder tom_decoder_chk u_chk (.*);
`default_nettype wire

// *** tom_cpu_model.sv ***
// access source standing in for the load/store path
// drives just after rising edges, one access per call
`timescale 1ns/100ps
`default_nettype none
module tom_cpu_model (input wire logic clk_i, output var logic valid_o, write_o,
	output var logic [51:0] addr_o, output var logic [4:0] type_o);
	initial {valid_o, write_o, addr_o, type_o} = 59'h0;
	task go(input logic [51:0] a, input logic w, input logic [4:0] t);
		@(posedge clk_i);
		{valid_o, write_o, addr_o, type_o} <= {1'h1, w, a, t};
		@(posedge clk_i);
		{valid_o, addr_o} <= {1'h0, ~a}; // released address scrambled
	endtask
endmodule // tom_cpu_model
`default_nettype wire

// *** top_of_memory_region_decoder_test.sv ***
// self-checking bench for the region decoder
// model drives accesses, bench drives registers
`timescale 1ns/100ps
`default_nettype none
module top_of_memory_region_decoder_test;
	logic clk = 0, rst = 1, wr = 0, v, w, m, ack, vo, il;
	logic [2:0] mt;
	logic [1:0] sel = 0;
	logic [63:0] wd = 0, q;
	logic [51:0] a;
	logic [4:0] t;
	int failures = 0, n_tests = 0;
	always #20 clk = ~clk;
	tom_cpu_model cpu (.clk_i(clk), .valid_o(v), .write_o(w), .addr_o(a), .type_o(t));
	tom_decoder dut (.ref_clk_i(clk), .reset_i(rst), .reg_wr_i(wr), .reg_rd_i(wr), .reg_sel_i(sel),
		.reg_wdata_i(wd), .reg_rdata_o(q), .reg_ack_o(ack), .acc_valid_i(v), .acc_addr_i(a),
		.acc_write_i(w), .acc_type_i(t), .acc_valid_o(vo), .acc_to_mem_o(m), .acc_in_limit_o(il),
		.acc_mem_type_o(mt));
	task check(input logic [63:0] s, e);
		n_tests++;
		if (s !== e) begin
			failures++;
			$display("FAIL %0t got %h want %h", $time, s, e);
		end
	endtask
	// write and read together: read returns the old value
	task rw(input logic [1:0] s, input logic [63:0] d, e);
		@(posedge clk);
		{wr, sel, wd} <= {1'h1, s, d};
		@(posedge clk);
		wr <= 1'h0;
		#1 check(q, e);
		check(ack, 1'h1);
	endtask
	task acc(input logic [51:0] ad, input logic wb, input logic [4:0] ty, input logic e);
		cpu.go(ad, wb, ty);
		#1 check(m, e);
		check(vo, 1'h1);
		check(mt, ty[2:0]);
	endtask
	task t_low;
		rw(2'h2, 64'h10_0000, 64'h0);
		rw(2'h0, 64'hfff0_0000_807f_ffff, 64'h0);
		acc(52'h7fff_ffff, 1'h0, 5'h18, 1'h1);
		acc(52'h7fff_ffff, 1'h0, 5'h08, 1'h0);
		check(il, 1'h1);
		acc(52'h0, 1'h1, 5'h10, 1'h0);
		acc(52'h8000_0000, 1'h1, 5'h18, 1'h0);
		check(il, 1'h0);
		acc(52'h1_0000_0000, 1'h0, 5'h18, 1'h0);
		check(il, 1'h0);
		rw(2'h2, 64'h0, 64'h10_0000);
		acc(52'h0, 1'h0, 5'h18, 1'h0);
		$display("low limit test done");
	endtask
	task t_high;
		rw(2'h2, 64'h30_0000, 64'h0);
		rw(2'h1, 64'h2_0000_0000, 64'h0);
		acc(52'h1_ffff_ffff, 1'h1, 5'h18, 1'h1);
		check(il, 1'h1);
		acc(52'h2_0000_0000, 1'h0, 5'h18, 1'h0);
		acc(52'hf_ffff_ffff_ffff, 1'h0, 5'h18, 1'h0);
		acc(52'h0, 1'h0, 5'h18, 1'h1);
		rw(2'h3, 64'h5, 64'h0);
		rw(2'h0, 64'h0, 64'hfff0_0000_807f_ffff);
		$display("high limit test done");
	endtask
	task t_reset;
		@(posedge clk);
		rst <= 1'h1;
		@(posedge clk);
		rst <= 1'h0;
		#1 check({ack, vo, m, il, mt}, 7'h0);
		rw(2'h0, 64'h0, 64'h0);
		acc(52'h0, 1'h0, 5'h18, 1'h0);
		$display("reset test done");
	endtask
	task results;
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		t_low;
		t_high;
		t_reset;
		results;
	end
	initial begin
		#20000;
		failures++;
		results;
	end
endmodule // top_of_memory_region_decoder_test
`default_nettype wire
